//--- usbrxs_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Status and fill state of one endpoint
module usbrxs_cell
    import usbrxs_pkg::*;
(
    input  wire logic              ref_clk,     // System clock
    input  wire logic              rst_b,       // Async reset, low
    input  wire logic              sie_hit,     // Bus event is for this ep
    input  wire logic              setup_tok,   // Valid SETUP token
    input  wire logic              out_tok,     // Valid OUT token
    input  wire logic              ack_sent,    // ACK handshake finished
    input  wire logic              rx_done,     // End of data reception
    input  wire logic              rx_good,     // Reception without error
    input  wire logic              sof,         // Start of frame
    input  wire logic              fifo_err,    // FIFO error present
    input  wire logic              fw_hit,      // Firmware selects this ep
    input  wire logic              st_wr,       // Status register write
    input  wire logic              cfg_wr,      // Config register write
    input  wire logic [7:0]        wdata,       // Firmware write data
    input  wire logic              rd_strobe,   // Firmware FIFO byte read
    output logic [7:0]             status,      // Status read value
    output logic [CFG_W-1:0]       cfg,         // Config read value
    output logic                   void_now,    // Void condition now
    output logic                   lock,        // Fill state locked
    output logic [1:0]             fill,        // Receive fill state
    output logic [RPTR_W-1:0]      rptr         // Receive read pointer
);

    // ========================================================
    // State
    logic tog_q, setup_q, ovs_q, ove_q, void_q, err_q, ack_q, stg_q;
    logic pv_q, pe_q, pa_q, pvv_q, pav_q;
    logic [CFG_W-1:0]  cfg_q;
    logic [1:0]        fill_q;
    logic [RPTR_W-1:0] rptr_q;

    // ========================================================
    // Event decode
    wire is_ctl   = cfg_q[CFG_CONTROL_BIT];
    wire is_iso   = cfg_q[CFG_ISO_BIT];
    wire e_setup  = sie_hit & setup_tok;
    wire e_out    = sie_hit & out_tok;
    wire e_done   = sie_hit & rx_done;
    wire e_sack   = sie_hit & ack_sent & stg_q;
    wire e_oack   = sie_hit & ack_sent & ~stg_q;
    wire e_wst    = fw_hit & st_wr;
    wire e_wcfg   = fw_hit & cfg_wr;
    wire e_sof    = sof & is_iso;
    // Void condition seen by an OUT token
    assign void_now = ~cfg_q[CFG_ENABLE_BIT] | cfg_q[CFG_RXSTALL_BIT] |
                      setup_q | (fill_q == FILL_FULL) | fifo_err;
    // Overwrite flags steer only control endpoints
    wire ovs_set  = e_setup & is_ctl;
    wire ovs_clr  = e_sack;
    wire ove_set  = e_sack & is_ctl;
    wire ove_clr  = e_wst & ~wdata[OVW_END_BIT];
    assign lock   = is_ctl & (ovs_q | ove_q);
    wire tog_fw   = e_wst & wdata[TOG_WEN_BIT];
    wire rel      = e_wcfg & wdata[CFG_RELEASE_BIT];
    wire grow     = e_done & rx_good & ~lock & (fill_q != FILL_FULL);
    wire shrink   = rel & ~lock & (fill_q != FILL_RESET);

    // ========================================================
    // Next values
    logic tog_d;
    always_comb begin
        tog_d = tog_q;
        if (e_oack) begin
            tog_d = ~tog_q;
        end
        if (tog_fw) begin
            tog_d = wdata[TOGGLE_BIT];
        end
        if (e_setup) begin
            tog_d = TOGGLE_AFTER_SETUP;
        end
    end

    // Hardware set wins over a firmware clear in the same cycle
    wire setup_d = e_setup | (setup_q & ~(e_wst & ~wdata[SETUP_BIT]));
    wire ovs_d   = ovs_set | (ovs_q & ~ovs_clr);
    wire ove_d   = ove_set | (ove_q & ~ove_clr);
    wire stg_d   = e_setup | (stg_q & ~(sie_hit & ack_sent));

    // ========================================================
    // Registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {tog_q, setup_q, ovs_q, ove_q} <= 4'h0;
            {void_q, err_q, ack_q, stg_q} <= 4'h0;
        end else begin
            tog_q   <= tog_d;
            setup_q <= setup_d;
            ovs_q   <= ovs_d;
            ove_q   <= ove_d;
            stg_q   <= stg_d;
            if (e_out && !is_iso) begin
                void_q <= void_now;
            end else if (e_sof && pvv_q) begin
                void_q <= pv_q;
            end
            if (e_done && !is_iso) begin
                err_q <= ~rx_good;
                ack_q <= rx_good;
            end else if (e_sof && pav_q) begin
                err_q <= pe_q;
                ack_q <= pa_q;
            end
        end
    end

    // Isochronous outcomes wait for the next start of frame
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {pv_q, pvv_q, pe_q, pa_q, pav_q} <= 5'h00;
        end else begin
            if (e_out && is_iso) begin
                pv_q  <= void_now;
                pvv_q <= 1'b1;
            end else if (e_sof) begin
                pvv_q <= 1'b0;
            end
            if (e_done && is_iso) begin
                pe_q  <= ~rx_good;
                pa_q  <= rx_good;
                pav_q <= 1'b1;
            end else if (e_sof) begin
                pav_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q  <= CFG_RESET;
            fill_q <= FILL_RESET;
            rptr_q <= RPTR_RESET;
        end else begin
            if (e_wcfg) begin
                cfg_q <= wdata[CFG_W-1:0];
            end
            if (ovs_set) begin
                fill_q <= FILL_RESET;
                rptr_q <= RPTR_RESET;
            end else begin
                if (grow) begin
                    fill_q <= fill_q + 2'h1;
                end else if (shrink) begin
                    fill_q <= fill_q - 2'h1;
                    rptr_q <= RPTR_RESET;
                end else if (fw_hit && rd_strobe && !lock) begin
                    rptr_q <= rptr_q + 6'h01;
                end
            end
        end
    end

    // ========================================================
    // Read view; the toggle write enable always reads zero
    assign status = {tog_q, setup_q, ovs_q, ove_q, 1'b0,
                     void_q, err_q, ack_q};
    assign cfg    = cfg_q;
    assign fill   = fill_q;
    assign rptr   = rptr_q;

endmodule : usbrxs_cell
`default_nettype wire

//--- usbrxs_pkg.sv
// ============================================================
// Shared constants for the endpoint receive status block
package usbrxs_pkg;

    // ========================================================
    // Sizes
    localparam int unsigned EP_COUNT    = 16;
    localparam int unsigned EP_IDX_W    = 4;
    localparam int unsigned RPTR_W      = 6;

    // ========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] RX_STATUS_IDX   = 8'h0D;
    localparam logic [7:0] EP_SELECT_IDX   = 8'h0E;
    localparam logic [7:0] EP_CONFIG_IDX   = 8'h0F;
    localparam logic [7:0] EP_FILL_IDX     = 8'h11;
    localparam logic [7:0] RX_STATUS_ADDR  = 8'h34;
    localparam logic [7:0] EP_SELECT_ADDR  = 8'h38;
    localparam logic [7:0] EP_CONFIG_ADDR  = 8'h3C;
    localparam logic [7:0] EP_FILL_ADDR    = 8'h44;

    // ========================================================
    // Receive status field positions
    localparam int unsigned TOGGLE_BIT    = 7;
    localparam int unsigned SETUP_BIT     = 6;
    localparam int unsigned OVW_START_BIT = 5;
    localparam int unsigned OVW_END_BIT   = 4;
    localparam int unsigned TOG_WEN_BIT   = 3;
    localparam int unsigned VOID_BIT      = 2;
    localparam int unsigned ERROR_BIT     = 1;
    localparam int unsigned ACK_BIT       = 0;

    // ========================================================
    // Endpoint configuration field positions
    localparam int unsigned CFG_CONTROL_BIT = 0;
    localparam int unsigned CFG_ENABLE_BIT  = 1;
    localparam int unsigned CFG_RXSTALL_BIT = 2;
    localparam int unsigned CFG_TXSTALL_BIT = 3;
    localparam int unsigned CFG_ISO_BIT     = 4;
    localparam int unsigned CFG_SHARED_ACCESS_PENDING_BIT    = 5;
    localparam int unsigned CFG_RELEASE_BIT = 7;
    localparam int unsigned CFG_W           = 6;

    // ========================================================
    // Reset values, the full fill level and the toggle value after SETUP
    localparam logic [7:0]        RX_STATUS_RESET = 8'h00;
    localparam logic [CFG_W-1:0]  CFG_RESET       = 6'h00;
    localparam logic [1:0]        FILL_RESET      = 2'h0;
    localparam logic [1:0]        FILL_FULL       = 2'h3;
    localparam logic [RPTR_W-1:0] RPTR_RESET      = 6'h00;
    localparam logic              TOGGLE_AFTER_SETUP = 1'b1;

endpackage : usbrxs_pkg

//--- usbrxs_top.sv
`timescale 1ns/1ps
`default_nettype none
module usbrxs_top
    import usbrxs_pkg::*;
(
    input  wire logic                ref_clk,         // System clock
    input  wire logic                rst_b,           // Async reset, low
    input  wire logic [7:0]          paddr,           // APB byte address
    input  wire logic                psel,            // APB select
    input  wire logic                penable,         // APB access phase
    input  wire logic                pwrite,          // APB direction
    input  wire logic [31:0]         pwdata,          // APB write data
    output logic [31:0]              prdata,          // APB read data
    output logic                     pready,          // APB ready
    output logic                     pslverr,         // APB error
    input  wire logic [EP_IDX_W-1:0] sie_ep,          // Endpoint of token
    input  wire logic                sie_setup_tok,   // Valid SETUP pulse
    input  wire logic                sie_out_tok,     // Valid OUT pulse
    input  wire logic                sie_in_tok,      // Valid IN pulse
    input  wire logic                sie_ack_sent,    // ACK sent pulse
    input  wire logic                sie_rx_done,     // Reception end pulse
    input  wire logic                sie_rx_good,     // Reception good
    input  wire logic                sie_sof,         // Start of frame
    input  wire logic                sie_fifo_err,    // FIFO error level
    input  wire logic                fifo_rd_strobe,  // FIFO byte read
    output logic                     sie_force_nak,   // Answer with NAK
    output logic                     sie_rx_void,     // OUT cannot land
    output logic [EP_COUNT-1:0]      rx_fifo_lock,    // Lock per endpoint
    output logic [1:0]               rx_fill_state,   // Selected ep fill
    output logic [RPTR_W-1:0]        rx_read_ptr      // Selected ep pointer
);

    // ========================================================
    // Bus decode
    logic [EP_IDX_W-1:0] endpoint_select_index_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic [1:0]          fill_q;
    logic [RPTR_W-1:0]   rptr_q;

    wire setup_phase = psel & ~penable;
    wire access      = psel & penable;
    wire hit_status  = (paddr == RX_STATUS_ADDR);
    wire hit_select  = (paddr == EP_SELECT_ADDR);
    wire hit_config  = (paddr == EP_CONFIG_ADDR);
    wire hit_fill    = (paddr == EP_FILL_ADDR);
    wire hit_any     = hit_status | hit_select | hit_config | hit_fill;
    wire wr_take     = access & pwrite & hit_any;
    wire st_wr       = wr_take & hit_status;
    wire cfg_wr      = wr_take & hit_config;

    // ========================================================
    // Endpoint cells
    logic [7:0]        status_v [EP_COUNT];
    logic [CFG_W-1:0]  cfg_v    [EP_COUNT];
    logic [1:0]        fill_v   [EP_COUNT];
    logic [RPTR_W-1:0] rptr_v   [EP_COUNT];
    logic [EP_COUNT-1:0] void_v;

    genvar gi;
    generate
        for (gi = 0; gi < EP_COUNT; gi++) begin : g_ep
            wire sie_hit = (sie_ep == EP_IDX_W'(gi));
            wire fw_hit  = (endpoint_select_index_q == EP_IDX_W'(gi));
            usbrxs_cell u_cell (
                .ref_clk   (ref_clk),
                .rst_b     (rst_b),
                .sie_hit   (sie_hit),
                .setup_tok (sie_setup_tok),
                .out_tok   (sie_out_tok),
                .ack_sent  (sie_ack_sent),
                .rx_done   (sie_rx_done),
                .rx_good   (sie_rx_good),
                .sof       (sie_sof),
                .fifo_err  (sie_fifo_err & sie_hit),
                .fw_hit    (fw_hit),
                .st_wr     (st_wr),
                .cfg_wr    (cfg_wr),
                .wdata     (pwdata[7:0]),
                .rd_strobe (fifo_rd_strobe),
                .status    (status_v[gi]),
                .cfg       (cfg_v[gi]),
                .void_now  (void_v[gi]),
                .lock      (rx_fifo_lock[gi]),
                .fill      (fill_v[gi]),
                .rptr      (rptr_v[gi])
            );
        end
    endgenerate

    // ========================================================
    // Token answers toward the serial engine
    wire [7:0] sie_status = status_v[sie_ep];
    wire       tok_any    = sie_in_tok | sie_out_tok;
    // Stall bits do not outrank a pending setup packet
    assign sie_force_nak = tok_any & sie_status[SETUP_BIT];
    assign sie_rx_void   = void_v[sie_ep];

    // ========================================================
    // Read mux
    wire [7:0] sel_status = status_v[endpoint_select_index_q];
    wire [31:0] rd_word =
        hit_status ? {24'h000000, sel_status} :
        hit_select ? {28'h0000000, endpoint_select_index_q} :
        hit_config ? {26'h0000000, cfg_v[endpoint_select_index_q]} :
        hit_fill   ? {23'h000000, rx_fifo_lock[endpoint_select_index_q],
                      rptr_v[endpoint_select_index_q],
                      fill_v[endpoint_select_index_q]} :
                     32'h00000000;

    // ========================================================
    // Registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            endpoint_select_index_q <= '0;
        end else if (wr_take && hit_select) begin
            endpoint_select_index_q <= pwdata[EP_IDX_W-1:0];
        end
    end

    // Read data is sampled in the setup cycle, so zero wait states
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_word;
            pslverr_q <= ~hit_any;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fill_q <= FILL_RESET;
            rptr_q <= RPTR_RESET;
        end else begin
            fill_q <= fill_v[endpoint_select_index_q];
            rptr_q <= rptr_v[endpoint_select_index_q];
        end
    end

    assign prdata        = prdata_q;
    assign pready        = 1'b1;
    assign pslverr       = pslverr_q & access;
    assign rx_fill_state = fill_q;
    assign rx_read_ptr   = rptr_q;

endmodule : usbrxs_top
`default_nettype wire

//--- usbrxs_rx_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the endpoint receive status block
module usbrxs_rx_assertions
    import usbrxs_pkg::*;
(
    input  wire logic                ref_clk,        // System clock
    input  wire logic                rst_b,          // Async reset, low
    input  wire logic [7:0]          paddr,          // APB address
    input  wire logic                psel,           // APB select
    input  wire logic                penable,        // APB access phase
    input  wire logic                pwrite,         // APB direction
    input  wire logic [31:0]         prdata,         // APB read data
    input  wire logic                pready,         // APB ready
    input  wire logic                pslverr,        // APB error
    input  wire logic                sie_setup_tok,  // SETUP pulse
    input  wire logic                sie_out_tok,    // OUT pulse
    input  wire logic                sie_in_tok,     // IN pulse
    input  wire logic                sie_force_nak,  // NAK request
    input  wire logic                sie_rx_void,    // Void condition
    input  wire logic [EP_COUNT-1:0] rx_fifo_lock    // Lock per endpoint
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire logic acc_q = psel && penable;
    wire logic mapped = (paddr == RX_STATUS_ADDR) || (paddr == EP_SELECT_ADDR)
                     || (paddr == EP_CONFIG_ADDR) || (paddr == EP_FILL_ADDR);

    chk_nak_cause: assert property (
        sie_force_nak |-> (sie_in_tok || sie_out_tok))
        else $error("NAK without a token");
    chk_void_on_nak: assert property (
        sie_out_tok && sie_force_nak |-> sie_rx_void)
        else $error("OUT NAKed for pending setup but not void");
    chk_lock_rise: assert property (
        $rose(|rx_fifo_lock) |-> $past(sie_setup_tok))
        else $error("FIFO lock set without a SETUP token");
    chk_lock_fall: assert property (
        $fell(|rx_fifo_lock) |-> $past(acc_q && pwrite))
        else $error("FIFO lock released without a firmware write");
    chk_wen_reads_zero: assert property (
        acc_q && !pwrite && paddr == RX_STATUS_ADDR |-> !prdata[TOG_WEN_BIT])
        else $error("Toggle write enable read back as one");
    // The fill view carries the lock flag in bit 8; all else reads zero
    chk_upper_zero: assert property (
        acc_q |-> prdata[31:9] == 23'h000000 &&
                  (paddr == EP_FILL_ADDR || !prdata[8]))
        else $error("Upper read data not zero");
    chk_slverr_map: assert property (
        acc_q |-> pslverr == !mapped)
        else $error("Slave error does not match address map");
    chk_ready_zero_wait: assert property (
        psel && !penable |=> pready)
        else $error("Access phase without ready");

    cover property (sie_force_nak && sie_out_tok);
    cover property ($fell(|rx_fifo_lock));
    cover property (acc_q && pslverr);
endmodule : usbrxs_rx_assertions
`default_nettype wire

//--- usbrxs_host.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// USB host side of the token link, one event per call
module usbrxs_host
    import usbrxs_pkg::*;
(
    input  wire logic           ref_clk,        // System clock
    input  wire logic           sie_force_nak,  // NAK request
    input  wire logic           sie_rx_void,    // Void condition
    output logic [EP_IDX_W-1:0] sie_ep,         // Token endpoint
    output logic                sie_setup_tok,  // SETUP pulse
    output logic                sie_out_tok,    // OUT pulse
    output logic                sie_in_tok,     // IN pulse
    output logic                sie_ack_sent,   // ACK sent pulse
    output logic                sie_rx_done,    // Reception end pulse
    output logic                sie_rx_good,    // Reception good
    output logic                sie_sof         // Start of frame
);
    logic last_nak;
    logic last_void;
    initial begin
        {sie_ep, sie_setup_tok, sie_out_tok, sie_in_tok} = '0;
        {sie_ack_sent, sie_rx_done, sie_rx_good, sie_sof} = '0;
    end
    // Kinds: 0 setup, 1 out, 2 in, 3 ack sent, 4 reception end, 5 SOF
    task automatic pulse(input logic [EP_IDX_W-1:0] ep, input int k,
                         input logic good);
        @(posedge ref_clk);
        sie_ep        <= ep;
        sie_setup_tok <= (k == 0);
        sie_out_tok   <= (k == 1);
        sie_in_tok    <= (k == 2);
        sie_ack_sent  <= (k == 3);
        sie_rx_done   <= (k == 4);
        sie_sof       <= (k == 5);
        sie_rx_good   <= good;
        @(negedge ref_clk);
        last_nak  = sie_force_nak;
        last_void = sie_rx_void;
        @(posedge ref_clk);
        // Idle endpoint and good lines show inverted values so nothing leans on stale data
        sie_ep      <= ~ep;
        sie_rx_good <= ~good;
        {sie_setup_tok, sie_out_tok, sie_in_tok} <= 3'h0;
        {sie_ack_sent, sie_rx_done, sie_sof}     <= 3'h0;
    endtask : pulse
endmodule : usbrxs_host
`default_nettype wire

//--- test_usbrxs_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_usbrxs_top
    import usbrxs_pkg::*;
;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [EP_IDX_W-1:0] sie_ep;
    logic setup_t, out_t, in_t, ack_s, rx_d, rx_g, sof, nak, rvoid, rd_stb;
    logic ferr;
    logic [EP_COUNT-1:0] lock;
    logic [1:0] fill;
    logic [RPTR_W-1:0] rptr;
    int mismatches, check_count, cycles;

    usbrxs_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sie_ep(sie_ep),
        .sie_setup_tok(setup_t), .sie_out_tok(out_t), .sie_in_tok(in_t),
        .sie_ack_sent(ack_s), .sie_rx_done(rx_d), .sie_rx_good(rx_g),
        .sie_sof(sof), .sie_fifo_err(ferr), .fifo_rd_strobe(rd_stb),
        .sie_force_nak(nak), .sie_rx_void(rvoid), .rx_fifo_lock(lock),
        .rx_fill_state(fill), .rx_read_ptr(rptr));
    usbrxs_host host (.ref_clk(ref_clk), .sie_force_nak(nak),
        .sie_rx_void(rvoid), .sie_ep(sie_ep), .sie_setup_tok(setup_t),
        .sie_out_tok(out_t), .sie_in_tok(in_t), .sie_ack_sent(ack_s),
        .sie_rx_done(rx_d), .sie_rx_good(rx_g), .sie_sof(sof));

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ========================================================
    // Bus and comparison helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge ref_clk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait for ready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask : wr
    task automatic st(input logic [3:0] ep, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        wr(EP_SELECT_ADDR, {28'h0, ep});
        apb(RX_STATUS_ADDR, 1'b0, 32'h0, r, e);
        check("rx status", r, {24'h0, exp});
    endtask : st
    task automatic view(input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(EP_FILL_ADDR, 1'b0, 32'h0, r, e);
        check("fill view", r, exp);
        check("fill pins", {24'h0, rptr, fill}, {24'h0, exp[7:0]});
    endtask : view
    task automatic cfg(input logic [3:0] ep, input logic [7:0] v);
        wr(EP_SELECT_ADDR, {28'h0, ep});
        wr(EP_CONFIG_ADDR, {24'h0, v});
    endtask : cfg
    task automatic out_stage(input logic [3:0] ep, input logic good);
        host.pulse(ep, 1, 1'b0);
        host.pulse(ep, 4, good);
        if (good)
            host.pulse(ep, 3, 1'b0);
    endtask : out_stage

    // ========================================================
    // Scenarios
    task automatic s_reset();
        logic [31:0] r;
        logic e;
        st(4'h0, 8'h00);
        apb(8'h40, 1'b0, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
    endtask : s_reset
    task automatic s_setup();
        cfg(4'h1, 8'h23);
        out_stage(4'h1, 1'b1);
        st(4'h1, 8'h81);
        @(posedge ref_clk) rd_stb <= 1'b1;
        @(posedge ref_clk) rd_stb <= 1'b0;
        view(32'h005);
        wr(RX_STATUS_ADDR, 32'h08);
        st(4'h1, 8'h01);
        host.pulse(4'h1, 0, 1'b1);
        st(4'h1, 8'hE1);
        view(32'h100);
        @(posedge ref_clk) rd_stb <= 1'b1;
        @(posedge ref_clk) rd_stb <= 1'b0;
        view(32'h100);
        host.pulse(4'h1, 4, 1'b1);
        cfg(4'h1, 8'h2F);
        host.pulse(4'h1, 2, 1'b0);
        check("nak on in", host.last_nak, 32'h1);
        host.pulse(4'h1, 1, 1'b0);
        check("nak on out", host.last_nak, 32'h1);
        check("void on out", host.last_void, 32'h1);
        host.pulse(4'h1, 3, 1'b0);
        st(4'h1, 8'hD5);
        view(32'h100);
        // Stalls are lifted before the setup flag goes
        cfg(4'h1, 8'h23);
        wr(RX_STATUS_ADDR, 32'h10);
        st(4'h1, 8'h95);
        host.pulse(4'h1, 2, 1'b0);
        check("no nak", host.last_nak, 32'h0);
        view(32'h100);
        wr(RX_STATUS_ADDR, 32'h00);
        st(4'h1, 8'h85);
        view(32'h000);
    endtask : s_setup
    task automatic s_toggle();
        out_stage(4'h1, 1'b0);
        st(4'h1, 8'h82);
        out_stage(4'h1, 1'b1);
        st(4'h1, 8'h01);
        wr(RX_STATUS_ADDR, 32'h80);
        st(4'h1, 8'h01);
        wr(RX_STATUS_ADDR, 32'h7F);
        st(4'h1, 8'h01);
        wr(RX_STATUS_ADDR, 32'h88);
        st(4'h1, 8'h81);
        ferr <= 1'b1;
        host.pulse(4'h1, 1, 1'b0);
        ferr <= 1'b0;
        check("void fifo err", host.last_void, 32'h1);
        st(4'h1, 8'h85);
        view(32'h001);
        wr(EP_CONFIG_ADDR, 32'hA3);
        view(32'h000);
    endtask : s_toggle
    task automatic s_other();
        cfg(4'h2, 8'h22);
        host.pulse(4'h2, 0, 1'b1);
        host.pulse(4'h2, 4, 1'b1);
        host.pulse(4'h2, 3, 1'b0);
        st(4'h2, 8'hC1);
        check("lock ep2", lock[2], 32'h0);
        host.pulse(4'h3, 1, 1'b0);
        check("void disabled", host.last_void, 32'h1);
        st(4'h3, 8'h04);
        cfg(4'h4, 8'h12);
        host.pulse(4'h4, 1, 1'b0);
        host.pulse(4'h4, 4, 1'b1);
        st(4'h4, 8'h00);
        host.pulse(4'h4, 5, 1'b0);
        st(4'h4, 8'h01);
    endtask : s_other

    initial begin
        {ref_clk, rst_b, psel, penable, pwrite, rd_stb, ferr} = '0;
        {paddr, pwdata} = '0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        s_reset();
        s_setup();
        s_toggle();
        s_other();
        conclude();
    end
endmodule : test_usbrxs_top

bind usbrxs_top usbrxs_rx_assertions chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sie_setup_tok(sie_setup_tok), .sie_out_tok(sie_out_tok),
    .sie_in_tok(sie_in_tok), .sie_force_nak(sie_force_nak),
    .sie_rx_void(sie_rx_void), .rx_fifo_lock(rx_fifo_lock));
`default_nettype wire
